// ### core/uart_register_map.sv
// host register bank of the serial port: decode, storage, status and identity
//
// Contract
// [RULE1] bit 0 of every register is the least significant host data bit
// [RULE2] character bit 0 goes first out and first received bit is bit 0
// [RULE3] character mode: identity bits 3,6,7 and line state bit 7 read zero
// [RULE4] offset 0 write loads transmit holding; read returns receive buffer only
// [RULE5] divisor access bit maps offsets 0 and 1 to divisor low and high
// [RULE6] any divisor byte write reloads the 16-bit baud counter at once
// [RULE7] line status code 06 outranks received data code 04
// [RULE8] modem state bits 7..4 follow current modem input levels
`timescale 1ns/100ps
module uart_register_map (
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  input  wire uart_regs_pkg::host_req_t    host_req_in,
  output logic [7:0]                       rd_data_out,
  input  wire uart_regs_pkg::rx_event_t    rx_event_in,
  input  wire logic                        tx_holding_empty_in,
  input  wire logic                        transmit_idle_in,
  input  wire uart_regs_pkg::modem_pins_t  modem_pins_in,
  output logic [7:0]                       tx_data_out,
  output logic                             tx_load_out,
  output logic [7:0]                       line_control_out,
  output logic [7:0]                       modem_control_out,
  output logic [7:0]                       irq_enable_out,
  output logic [15:0]                      divisor_out,
  output logic                             baud_reload_out,
  output logic                             fifo_enable_out,
  output logic                             dma_mode_out,
  output logic [1:0]                       rx_trigger_out,
  output logic                             rx_fifo_reset_out,
  output logic                             tx_fifo_reset_out
);
  import uart_regs_pkg::*;

  state_t      st_r;
  state_t      st_nxt;
  modem_pins_t modem_now;
  logic [3:0]  iid;
  logic [7:0]  ident_byte;
  logic [7:0]  line_byte;
  logic [7:0]  modem_byte;
  logic        div_access;
  logic        rd_hit;
  logic        wr_hit;

  //////////////////////////////////////////////////////////////////////////////
  // status views

  always_comb begin
    div_access = st_r.line_ctl[LC_DIV_ACCESS];
    // loopback feeds modem control back as the modem inputs
    if (st_r.modem_ctl[MC_LOOP]) begin
      modem_now.cts = st_r.modem_ctl[MC_RTS];
      modem_now.dsr = st_r.modem_ctl[MC_DTR];
      modem_now.ri  = st_r.modem_ctl[MC_OUT1];
      modem_now.dcd = st_r.modem_ctl[MC_OUT2];
    end else begin
      modem_now = st_r.pin_sync;
    end

    // [RULE7] identity priority order
    if (st_r.irq_en[IE_LINE_ERR] && (st_r.errs != '0)) begin
      iid = IID_LINE;
    end else if (st_r.irq_en[IE_RX_DATA] && st_r.rx_avail) begin
      iid = IID_RX_DATA;
    end else if (st_r.irq_en[IE_TX_EMPTY] && st_r.tx_pending) begin
      iid = IID_TX_EMPTY;
    end else if (st_r.irq_en[IE_MODEM] && (st_r.modem_delta != '0)) begin
      iid = IID_MODEM;
    end else begin
      iid = IID_NONE;
    end

    // [RULE3] fifo flags and timeout bit zero in character mode
    // timeout reporting belongs to the fifo logic, so bit 3 never sets here
    ident_byte = {st_r.fifo_on, st_r.fifo_on, 2'b00, 1'b0, iid[2:0]};

    // [RULE3] fifo error summary only in fifo mode
    line_byte = {st_r.fifo_on && (st_r.errs != '0),
                 transmit_idle_in,
                 tx_holding_empty_in,
                 st_r.errs.brk,
                 st_r.errs.framing,
                 st_r.errs.parity,
                 st_r.errs.overrun,
                 st_r.rx_avail};

    // [RULE8] upper nibble is the live input level, not stored
    modem_byte = {modem_now.dcd, modem_now.ri, modem_now.dsr, modem_now.cts,
                  st_r.modem_delta};
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt             = st_r;
    st_nxt.tx_load     = 1'b0;
    st_nxt.baud_reload = 1'b0;
    st_nxt.rx_fifo_rst = 1'b0;
    st_nxt.tx_fifo_rst = 1'b0;
    rd_hit             = host_req_in.rd;
    wr_hit             = host_req_in.wr;

    // two-flop synchroniser on the modem pins
    st_nxt.pin_meta   = modem_pins_in;
    st_nxt.pin_sync   = st_r.pin_meta;
    st_nxt.modem_prev = modem_now;

    // modem change flags: a change in the read cycle survives the clear
    if (rd_hit && host_req_in.addr == OFS_MODEM_ST) begin
      st_nxt.modem_delta = '0;
    end
    st_nxt.modem_delta[0] = st_nxt.modem_delta[0] | (modem_now.cts ^ st_r.modem_prev.cts);
    st_nxt.modem_delta[1] = st_nxt.modem_delta[1] | (modem_now.dsr ^ st_r.modem_prev.dsr);
    st_nxt.modem_delta[2] = st_nxt.modem_delta[2] | (st_r.modem_prev.ri & ~modem_now.ri);
    st_nxt.modem_delta[3] = st_nxt.modem_delta[3] | (modem_now.dcd ^ st_r.modem_prev.dcd);

    // line errors clear on a line state read; new errors win
    if (rd_hit && host_req_in.addr == OFS_LINE_ST) begin
      st_nxt.errs = '0;
    end

    // receive buffer: reading it clears the ready flag
    if (rd_hit && host_req_in.addr == OFS_DATA && !div_access) begin
      st_nxt.rx_avail = 1'b0;
    end
    if (rx_event_in.valid) begin
      // [RULE2] byte arrives with first received bit already in bit 0
      st_nxt.rx_byte  = rx_event_in.data;
      st_nxt.rx_avail = 1'b1;
      // an unread character being replaced is an overrun
      if (st_r.rx_avail && !(rd_hit && host_req_in.addr == OFS_DATA && !div_access)) begin
        st_nxt.errs.overrun = 1'b1;
      end
    end
    st_nxt.errs.overrun = st_nxt.errs.overrun | (rx_event_in.valid & rx_event_in.overrun);
    st_nxt.errs.parity  = st_nxt.errs.parity  | (rx_event_in.valid & rx_event_in.parity);
    st_nxt.errs.framing = st_nxt.errs.framing | (rx_event_in.valid & rx_event_in.framing);
    st_nxt.errs.brk     = st_nxt.errs.brk     | (rx_event_in.valid & rx_event_in.brk);

    // transmit empty event: reading its identity or writing the holding byte clears
    st_nxt.tx_empty_prev = tx_holding_empty_in;
    if (rd_hit && host_req_in.addr == OFS_IDENT && iid == IID_TX_EMPTY) begin
      st_nxt.tx_pending = 1'b0;
    end
    if (wr_hit && host_req_in.addr == OFS_DATA && !div_access) begin
      st_nxt.tx_pending = 1'b0;
    end
    if (tx_holding_empty_in && !st_r.tx_empty_prev) begin
      st_nxt.tx_pending = 1'b1;
    end

    // read data; write-only registers never echo back
    if (rd_hit) begin
      // [RULE1] every byte is placed with bit 0 on host data bit 0
      unique case (host_req_in.addr)
        // [RULE5] divisor overlay on offset 0
        // [RULE4] offset 0 returns receive buffer, never transmit value
        OFS_DATA:      st_nxt.rd_data = div_access ? st_r.divisor[7:0] : st_r.rx_byte;
        // [RULE5] divisor overlay on offset 1
        OFS_IRQ_EN:    st_nxt.rd_data = div_access ? st_r.divisor[15:8] : st_r.irq_en;
        OFS_IDENT:     st_nxt.rd_data = ident_byte;
        OFS_LINE_CTL:  st_nxt.rd_data = st_r.line_ctl;
        OFS_MODEM_CTL: st_nxt.rd_data = st_r.modem_ctl;
        OFS_LINE_ST:   st_nxt.rd_data = line_byte;
        OFS_MODEM_ST:  st_nxt.rd_data = modem_byte;
        OFS_SCRATCH:   st_nxt.rd_data = st_r.scratch;
      endcase
    end

    if (wr_hit) begin
      unique case (host_req_in.addr)
        OFS_DATA: begin
          if (div_access) begin
            // [RULE6] low byte write reloads baud counter
            st_nxt.divisor[7:0] = host_req_in.data;
            st_nxt.baud_reload  = 1'b1;
          end else begin
            // [RULE4] offset 0 write loads transmit holding
            // [RULE2] bit 0 stays in bit 0 for the lsb-first shifter
            st_nxt.tx_byte = host_req_in.data;
            st_nxt.tx_load = 1'b1;
          end
        end
        OFS_IRQ_EN: begin
          if (div_access) begin
            // [RULE6] high byte write reloads baud counter
            st_nxt.divisor[15:8] = host_req_in.data;
            st_nxt.baud_reload   = 1'b1;
          end else begin
            st_nxt.irq_en = host_req_in.data & IRQ_EN_MASK;
          end
        end
        OFS_IDENT: begin
          st_nxt.fifo_on    = host_req_in.data[FC_ENABLE];
          st_nxt.dma_mode   = host_req_in.data[FC_DMA_MODE];
          st_nxt.rx_trigger = host_req_in.data[FC_TRIG_LSB +: 2];
          // toggling fifo mode empties both fifos as well
          st_nxt.rx_fifo_rst = host_req_in.data[FC_RX_RESET] |
                               (host_req_in.data[FC_ENABLE] ^ st_r.fifo_on);
          st_nxt.tx_fifo_rst = host_req_in.data[FC_TX_RESET] |
                               (host_req_in.data[FC_ENABLE] ^ st_r.fifo_on);
        end
        OFS_LINE_CTL:  st_nxt.line_ctl  = host_req_in.data;
        OFS_MODEM_CTL: st_nxt.modem_ctl = host_req_in.data & MODEM_CTL_MASK;
        OFS_SCRATCH:   st_nxt.scratch   = host_req_in.data;
        // status registers ignore writes
        OFS_LINE_ST,
        OFS_MODEM_ST:  st_nxt.scratch   = st_nxt.scratch;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r         <= '0;
      st_r.rd_data <= RST_BYTE;
      st_r.divisor <= RST_DIVISOR;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data_out       = st_r.rd_data;
  assign tx_data_out       = st_r.tx_byte;
  assign tx_load_out       = st_r.tx_load;
  assign line_control_out  = st_r.line_ctl;
  assign modem_control_out = st_r.modem_ctl;
  assign irq_enable_out    = st_r.irq_en;
  assign divisor_out       = st_r.divisor;
  assign baud_reload_out   = st_r.baud_reload;
  assign fifo_enable_out   = st_r.fifo_on;
  assign dma_mode_out      = st_r.dma_mode;
  assign rx_trigger_out    = st_r.rx_trigger;
  assign rx_fifo_reset_out = st_r.rx_fifo_rst;
  assign tx_fifo_reset_out = st_r.tx_fifo_rst;
endmodule : uart_register_map

// ### core/uart_regs_pkg.sv
// constants and carrier types for the serial port register bank
package uart_regs_pkg;
  // register offsets (address lines 2..0)
  localparam logic [2:0] OFS_DATA     = 3'h0;
  localparam logic [2:0] OFS_IRQ_EN   = 3'h1;
  localparam logic [2:0] OFS_IDENT    = 3'h2;
  localparam logic [2:0] OFS_LINE_CTL = 3'h3;
  localparam logic [2:0] OFS_MODEM_CTL= 3'h4;
  localparam logic [2:0] OFS_LINE_ST  = 3'h5;
  localparam logic [2:0] OFS_MODEM_ST = 3'h6;
  localparam logic [2:0] OFS_SCRATCH  = 3'h7;

  // field positions
  localparam int LC_DIV_ACCESS   = 7;
  localparam int MC_DTR          = 0;
  localparam int MC_RTS          = 1;
  localparam int MC_OUT1         = 2;
  localparam int MC_OUT2         = 3;
  localparam int MC_LOOP         = 4;
  localparam int FC_ENABLE       = 0;
  localparam int FC_RX_RESET     = 1;
  localparam int FC_TX_RESET     = 2;
  localparam int FC_DMA_MODE     = 3;
  localparam int FC_TRIG_LSB     = 6;
  localparam int IE_RX_DATA      = 0;
  localparam int IE_TX_EMPTY     = 1;
  localparam int IE_LINE_ERR     = 2;
  localparam int IE_MODEM        = 3;

  // writable widths of the enable and modem control registers
  localparam logic [7:0] IRQ_EN_MASK    = 8'h0f;
  localparam logic [7:0] MODEM_CTL_MASK = 8'h1f;

  // interrupt identity codes in bits 3..0
  localparam logic [3:0] IID_NONE     = 4'h1;
  localparam logic [3:0] IID_LINE     = 4'h6;
  localparam logic [3:0] IID_RX_DATA  = 4'h4;
  localparam logic [3:0] IID_TX_EMPTY = 4'h2;
  localparam logic [3:0] IID_MODEM    = 4'h0;

  // reset values
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_DIVISOR = 16'h0000;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] data;
  } host_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       overrun;
    logic       parity;
    logic       framing;
    logic       brk;
  } rx_event_t;

  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_pins_t;

  typedef struct packed {
    logic brk;
    logic framing;
    logic parity;
    logic overrun;
  } line_err_t;

  typedef struct packed {
    logic [7:0]  rd_data;
    logic [7:0]  rx_byte;
    logic        rx_avail;
    line_err_t   errs;
    logic [7:0]  tx_byte;
    logic        tx_load;
    logic        tx_empty_prev;
    logic        tx_pending;
    logic [7:0]  irq_en;
    logic [7:0]  line_ctl;
    logic [7:0]  modem_ctl;
    logic [7:0]  scratch;
    logic [15:0] divisor;
    logic        baud_reload;
    logic        fifo_on;
    logic        dma_mode;
    logic [1:0]  rx_trigger;
    logic        rx_fifo_rst;
    logic        tx_fifo_rst;
    modem_pins_t pin_meta;
    modem_pins_t pin_sync;
    modem_pins_t modem_prev;
    logic [3:0]  modem_delta;
  } state_t;
endpackage : uart_regs_pkg

// ### sim/tb_top.sv
// self-checking bench for the serial port register bank
`timescale 1ns/100ps
module tb_top;
  import uart_regs_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  host_req_t   req;
  rx_event_t   rx_ev = '0;
  modem_pins_t pins = '0;
  logic        thr_empty = 1'b0;
  logic        tx_idle = 1'b0;
  logic [7:0]  rd_data, tx_data, lc, mc, ie, q, r0, r1;
  logic [15:0] div;
  logic        tx_load, fifo_on;
  logic        baud_rl, dma, rx_rst, tx_rst;
  logic [1:0]  trig;
  int          fail_count = 0;
  int          compares = 0;
  always #5 clk_in = ~clk_in;
  uart_host_model host (.clk_in(clk_in), .rd_data_in(rd_data), .req_out(req));
  uart_register_map dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .host_req_in(req),
    .rd_data_out(rd_data), .rx_event_in(rx_ev), .tx_holding_empty_in(thr_empty),
    .transmit_idle_in(tx_idle), .modem_pins_in(pins), .tx_data_out(tx_data),
    .tx_load_out(tx_load), .line_control_out(lc), .modem_control_out(mc),
    .irq_enable_out(ie), .divisor_out(div), .baud_reload_out(baud_rl),
    .fifo_enable_out(fifo_on), .dma_mode_out(dma), .rx_trigger_out(trig),
    .rx_fifo_reset_out(rx_rst), .tx_fifo_reset_out(tx_rst));
  ////////////////////////////////////////////////////////////
  function automatic logic [3:0] loop_nib(input logic [7:0] m);
    return {m[3], m[2], m[0], m[1]};
  endfunction : loop_nib
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rd_chk(input string n, input logic [2:0] a, input logic [7:0] e);
    host.rd(a, q);
    chk(n, e, q);
  endtask : rd_chk
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(73));
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd_chk("ident", OFS_IDENT, 8'h01);
    $display("test reset done");
    repeat (8) begin
      r0 = 8'($urandom);
      r1 = 8'($urandom) & 8'h7f;
      host.put(1'b1, 1'b0, OFS_SCRATCH, r0);
      host.put(1'b0, 1'b1, OFS_SCRATCH, 8'h00);
      host.idle();
      chk("scratch", r0, rd_data);
      host.wr(OFS_LINE_CTL, r1);
      chk("line_ctl_out", r1, lc);
      rd_chk("line_ctl", OFS_LINE_CTL, r1);
    end
    $display("test random regs done");
    host.wr(OFS_LINE_CTL, 8'h80);
    host.wr(OFS_DATA, r0);
    chk("reload_low", 8'h01, {7'h00, baud_rl});
    host.wr(OFS_IRQ_EN, r1);
    chk("reload_high", 8'h01, {7'h00, baud_rl});
    chk("div_low", r0, div[7:0]);
    chk("div_high", r1, div[15:8]);
    chk("irq_en", 8'h00, ie);
    rd_chk("div_low", OFS_DATA, r0);
    host.wr(OFS_LINE_CTL, 8'h00);
    host.wr(OFS_DATA, ~r0);
    chk("tx_data", ~r0, tx_data);
    chk("tx_load", 8'h01, {7'h00, tx_load});
    chk("no_reload", 8'h00, {7'h00, baud_rl});
    $display("test divisor done");
    host.wr(OFS_IRQ_EN, 8'h05);
    r1 = 8'($urandom);
    @(posedge clk_in);
    rx_ev <= '{1'b1, r1, 1'b0, 1'b1, 1'b0, 1'b0};
    @(posedge clk_in);
    rx_ev <= '{1'b0, ~r1, 1'b0, 1'b0, 1'b0, 1'b0};
    rd_chk("ident", OFS_IDENT, 8'h06);
    rd_chk("line_st", OFS_LINE_ST, 8'h05);
    rd_chk("ident", OFS_IDENT, 8'h04);
    rd_chk("rx_buf", OFS_DATA, r1);
    rd_chk("ident", OFS_IDENT, 8'h01);
    $display("test priority done");
    @(posedge clk_in);
    pins <= modem_pins_t'(4'($urandom));
    repeat (4) @(posedge clk_in);
    host.rd(OFS_MODEM_ST, q);
    chk("modem_pins", {pins, pins.dcd, 1'b0, pins.dsr, pins.cts}, q);
    rd_chk("modem_clr", OFS_MODEM_ST, {pins, 4'h0});
    host.wr(OFS_MODEM_CTL, r0 | 8'h10);
    chk("mc_out", (r0 | 8'h10) & MODEM_CTL_MASK, mc);
    host.rd(OFS_MODEM_ST, q);
    chk("loopback", {loop_nib(r0), 4'h0}, {q[7:4], 4'h0});
    host.wr(OFS_MODEM_CTL, 8'h00);
    $display("test modem done");
    @(posedge clk_in);
    thr_empty <= 1'b1;
    tx_idle <= 1'b1;
    host.wr(OFS_IDENT, 8'hc9);
    chk("fifo_on", 8'h01, {7'h00, fifo_on});
    chk("fifo_ctl", 8'h1f, {3'h0, dma, rx_rst, tx_rst, trig});
    rd_chk("ident", OFS_IDENT, 8'hc1);
    chk("fifo_pulse", 8'h13, {3'h0, dma, rx_rst, tx_rst, trig});
    rd_chk("line_st", OFS_LINE_ST, 8'h60);
    @(posedge clk_in);
    rx_ev <= '{1'b1, r1, 1'b0, 1'b0, 1'b1, 1'b0};
    @(posedge clk_in);
    rx_ev <= '{1'b0, ~r1, 1'b0, 1'b0, 1'b0, 1'b0};
    rd_chk("line_st", OFS_LINE_ST, 8'he9);
    $display("test fifo mode done");
    host.rd(OFS_MODEM_ST, q);
    host.wr(OFS_IRQ_EN, 8'h0a);
    rd_chk("ident", OFS_IDENT, 8'hc2);
    @(posedge clk_in);
    pins <= modem_pins_t'(~pins);
    repeat (4) @(posedge clk_in);
    rd_chk("ident", OFS_IDENT, 8'hc0);
    host.rd(OFS_MODEM_ST, q);
    rd_chk("ident", OFS_IDENT, 8'hc1);
    $display("test low priority done");
    report_and_stop();
  end
endmodule : tb_top

// ### sim/uart_host_model.sv
// host cpu model issuing single-cycle register accesses
`timescale 1ns/100ps
module uart_host_model (
  input  wire logic                clk_in,
  input  wire logic [7:0]          rd_data_in,
  output uart_regs_pkg::host_req_t req_out
);
  import uart_regs_pkg::*;
  initial req_out = '0;
  ////////////////////////////////////////////////////////////
  // one strobe per cycle
  task automatic put(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req_out <= '{w, r, a, d};
  endtask : put
  // released data lines show the inverse so a stale byte is never reused
  task automatic idle();
    @(posedge clk_in);
    req_out <= '{1'b0, 1'b0, req_out.addr, ~req_out.data};
    #1;
  endtask : idle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    put(1'b1, 1'b0, a, d);
    idle();
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] q);
    put(1'b0, 1'b1, a, 8'h00);
    idle();
    q = rd_data_in;
  endtask : rd
endmodule : uart_host_model

// ### sim/uart_register_map_props.sv
// assertion checker for the serial port register bank
`timescale 1ns/100ps
module uart_regs_props (
  input wire logic                      clk_in,
  input wire logic                      rst_n_in,
  input wire uart_regs_pkg::host_req_t  host_req_in,
  input wire logic [7:0]                rd_data_out,
  input wire logic [7:0]                tx_data_out,
  input wire logic                      tx_load_out,
  input wire logic [7:0]                line_control_out,
  input wire logic [7:0]                modem_control_out,
  input wire logic [7:0]                irq_enable_out,
  input wire logic [15:0]               divisor_out,
  input wire logic                      baud_reload_out,
  input wire logic                      fifo_enable_out
);
  import uart_regs_pkg::*;
  wire logic       wr = host_req_in.wr;
  wire logic       rd = host_req_in.rd;
  wire logic [2:0] a = host_req_in.addr;
  wire logic [7:0] d = host_req_in.data;
  wire logic       dl = line_control_out[LC_DIV_ACCESS];
  wire logic       div_wr = wr && a[2:1] == 2'b00 && dl;
  wire logic [3:0] loop_nib = {modem_control_out[3:2], modem_control_out[0], modem_control_out[1]};
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////
  sequence s_scr_wr; wr && a == OFS_SCRATCH; endsequence
  sequence s_scr_rd; rd && a == OFS_SCRATCH; endsequence
  property p_scratch; s_scr_wr ##1 s_scr_rd |=> rd_data_out == $past(d, 2); endproperty
  property p_tx_load; wr && a == OFS_DATA && !dl |=> tx_load_out && tx_data_out == $past(d);
  endproperty
  property p_div_lo; div_wr && !a[0] |=> divisor_out[7:0] == $past(d) && !tx_load_out
    && baud_reload_out; endproperty
  property p_div_hi; div_wr && a[0] |=> divisor_out[15:8] == $past(d) && $stable(irq_enable_out)
    && baud_reload_out; endproperty
  property p_reload; baud_reload_out |-> $past(div_wr); endproperty
  property p_ident_chr; rd && a == OFS_IDENT && !fifo_enable_out |=> rd_data_out[7:6] == 2'b00
    && !rd_data_out[3]; endproperty
  property p_lsr_chr; rd && a == OFS_LINE_ST && !fifo_enable_out |=> !rd_data_out[7]; endproperty
  property p_ident_off; rd && a == OFS_IDENT && irq_enable_out == 8'h00
    |=> rd_data_out[3:0] == IID_NONE; endproperty
  property p_loop; rd && a == OFS_MODEM_ST && modem_control_out[MC_LOOP]
    |=> rd_data_out[7:4] == $past(loop_nib); endproperty
  a_scratch: assert property (p_scratch) else $error("scratch readback wrong");
  a_tx_load: assert property (p_tx_load) else $error("transmit load wrong");
  a_div_lo: assert property (p_div_lo) else $error("divisor low wrong");
  a_div_hi: assert property (p_div_hi) else $error("divisor high wrong");
  a_reload: assert property (p_reload) else $error("reload without write");
  a_ident_chr: assert property (p_ident_chr) else $error("identity bits set");
  a_lsr_chr: assert property (p_lsr_chr) else $error("line state bit7 set");
  a_ident_off: assert property (p_ident_off) else $error("masked identity");
  a_loop: assert property (p_loop) else $error("loopback levels wrong");
endmodule : uart_regs_props
bind uart_register_map uart_regs_props chk (.clk_in, .rst_n_in, .host_req_in, .rd_data_out,
  .tx_data_out, .tx_load_out, .line_control_out, .modem_control_out, .irq_enable_out,
  .divisor_out, .baud_reload_out, .fifo_enable_out);
